// ---- rtl/timer16_capture_compare.sv ----
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module timer16_capture_compare #(
    parameter int FILT_DEPTH = 4
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timer clock tick (same domain, one cycle pulse)
    input wire logic timer_tick,
    // Trigger inputs (asynchronous)
    input wire logic capture_input_pin,
    input wire logic comparator_output,
    // Interrupt requests and service acknowledges
    output logic capture_irq,
    output logic compare_a_irq,
    output logic compare_b_irq,
    input wire logic capture_irq_ack,
    input wire logic compare_a_irq_ack,
    input wire logic compare_b_irq_ack,
    // Counter state for the waveform side
    output logic [15:0] counter_value,
    output logic compare_a_match,
    output logic compare_b_match
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic cap_is_top(input logic [3:0] m);
        cap_is_top = (m == 4'h8) || (m == 4'hA) ||
                     (m == timer16_cc_pkg::MODE_CTC_CAP) ||
                     (m == 4'hE);
    endfunction

    function automatic logic cmpa_is_top(input logic [3:0] m);
        cmpa_is_top = (m == timer16_cc_pkg::MODE_CTC_A) ||
                      (m == 4'h9) || (m == 4'hB) || (m == 4'hF);
    endfunction

    function automatic logic is_pwm(input logic [3:0] m);
        is_pwm = (m != timer16_cc_pkg::MODE_NORMAL) &&
                 (m != timer16_cc_pkg::MODE_CTC_A) &&
                 (m != timer16_cc_pkg::MODE_CTC_CAP) &&
                 (m != timer16_cc_pkg::MODE_RSVD);
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[1:0] == 2'b00) &&
                  (a <= timer16_cc_pkg::OFF_IRQ_FLAG);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    timer16_cc_pkg::ctrl_t ctrl;
    timer16_cc_pkg::irq_t irq_mask;
    timer16_cc_pkg::irq_t flags;
    logic [15:0] capture_value_reg;
    logic [15:0] cmp_a_active;
    logic [15:0] cmp_b_active;
    logic [15:0] cmp_a_buf;
    logic [15:0] cmp_b_buf;
    logic [7:0] temp_hi;
    logic block_match;

    logic aw_held;
    logic w_held;
    logic [7:0] wr_addr;
    logic [7:0] wr_byte;
    logic wr_strb;
    logic [1:0] pin_meta;
    logic [1:0] pin_sync2;
    logic [FILT_DEPTH-1:0] filt_pipe;
    logic filt_out;
    logic edge_prev;

    // ------------------------------------------------------------
    // Mode decode and top selection
    // ------------------------------------------------------------
    wire [3:0] mode = ctrl.mode;
    wire mode_cap_top = cap_is_top(mode);
    wire mode_pwm = is_pwm(mode);
    wire [15:0] fixed_top =
        (mode[1:0] == 2'b01) ? timer16_cc_pkg::TOP_8BIT :
        (mode[1:0] == 2'b10) ? timer16_cc_pkg::TOP_9BIT :
        (mode[1:0] == 2'b11) ? timer16_cc_pkg::TOP_10BIT :
        timer16_cc_pkg::TOP_MAX;
    wire [15:0] top_value =
        mode_cap_top ? capture_value_reg :
        cmpa_is_top(mode) ? cmp_a_active :
        (mode == timer16_cc_pkg::MODE_NORMAL) ?
        timer16_cc_pkg::TOP_MAX : fixed_top;
    wire at_top = (counter_value == top_value);
    wire reload = timer_tick && at_top;

    // ------------------------------------------------------------
    // Bus handshake and decode
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire wr_go = aw_held && w_held;
    wire rd_go = s_axi_arvalid && s_axi_arready;
    wire wr_en = wr_go && wr_strb && addr_ok(wr_addr);

    wire wr_cnt_lo = wr_en && (wr_addr == timer16_cc_pkg::OFF_COUNT_LO);
    wire wr_cap_lo = wr_en && (wr_addr == timer16_cc_pkg::OFF_CAP_LO);
    wire wr_a_lo = wr_en && (wr_addr == timer16_cc_pkg::OFF_CMPA_LO);
    wire wr_b_lo = wr_en && (wr_addr == timer16_cc_pkg::OFF_CMPB_LO);
    wire wr_hi = wr_en && ((wr_addr == timer16_cc_pkg::OFF_COUNT_HI) ||
                           (wr_addr == timer16_cc_pkg::OFF_CAP_HI) ||
                           (wr_addr == timer16_cc_pkg::OFF_CMPA_HI) ||
                           (wr_addr == timer16_cc_pkg::OFF_CMPB_HI));
    wire wr_ctrl_a = wr_en && (wr_addr == timer16_cc_pkg::OFF_CTRL_A);
    wire wr_ctrl_b = wr_en && (wr_addr == timer16_cc_pkg::OFF_CTRL_B);
    wire wr_acmp = wr_en && (wr_addr == timer16_cc_pkg::OFF_ACMP_CTRL);
    wire wr_mask = wr_en && (wr_addr == timer16_cc_pkg::OFF_IRQ_MASK);
    wire wr_flag = wr_en && (wr_addr == timer16_cc_pkg::OFF_IRQ_FLAG);
    wire [15:0] wr_word = {temp_hi, wr_byte};

    wire rd_cnt_lo = rd_go && (s_axi_araddr == timer16_cc_pkg::OFF_COUNT_LO);
    wire rd_cap_lo = rd_go && (s_axi_araddr == timer16_cc_pkg::OFF_CAP_LO);

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    wire [15:0] cmp_a_view = mode_pwm ? cmp_a_buf : cmp_a_active;
    wire [15:0] cmp_b_view = mode_pwm ? cmp_b_buf : cmp_b_active;
    wire [7:0] ctrl_b_view =
        {ctrl.filt_en, ctrl.edge_rise, 1'b0, ctrl.mode[3:2], 3'b000};
    wire [7:0] acmp_view = {5'b00000, ctrl.cap_sel, 2'b00};
    wire [7:0] rd_byte =
        (s_axi_araddr == timer16_cc_pkg::OFF_COUNT_LO) ?
            counter_value[7:0] :
        (s_axi_araddr == timer16_cc_pkg::OFF_COUNT_HI) ? temp_hi :
        (s_axi_araddr == timer16_cc_pkg::OFF_CAP_LO) ?
            capture_value_reg[7:0] :
        (s_axi_araddr == timer16_cc_pkg::OFF_CAP_HI) ? temp_hi :
        (s_axi_araddr == timer16_cc_pkg::OFF_CMPA_LO) ? cmp_a_view[7:0] :
        (s_axi_araddr == timer16_cc_pkg::OFF_CMPA_HI) ? cmp_a_view[15:8] :
        (s_axi_araddr == timer16_cc_pkg::OFF_CMPB_LO) ? cmp_b_view[7:0] :
        (s_axi_araddr == timer16_cc_pkg::OFF_CMPB_HI) ? cmp_b_view[15:8] :
        (s_axi_araddr == timer16_cc_pkg::OFF_CTRL_A) ?
            {6'b000000, ctrl.mode[1:0]} :
        (s_axi_araddr == timer16_cc_pkg::OFF_CTRL_B) ? ctrl_b_view :
        (s_axi_araddr == timer16_cc_pkg::OFF_ACMP_CTRL) ? acmp_view :
        (s_axi_araddr == timer16_cc_pkg::OFF_IRQ_MASK) ?
            {5'b00000, irq_mask.cmp_b, irq_mask.cmp_a, irq_mask.cap} :
        (s_axi_araddr == timer16_cc_pkg::OFF_IRQ_FLAG) ?
            {5'b00000, flags.cmp_b, flags.cmp_a, flags.cap} :
        8'h00;

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= 8'h00;
            wr_byte <= 8'h00;
            wr_strb <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= timer16_cc_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                wr_byte <= s_axi_wdata[7:0];
                wr_strb <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_ok(wr_addr) ?
                    timer16_cc_pkg::RESP_OKAY :
                    timer16_cc_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= timer16_cc_pkg::RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= addr_ok(s_axi_araddr) ?
                timer16_cc_pkg::RESP_OKAY :
                timer16_cc_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Shared high-byte latch
    // ------------------------------------------------------------
    // A write beats a simultaneous low-byte read so software data wins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            temp_hi <= 8'h00;
        end else if (wr_hi) begin
            temp_hi <= wr_byte;
        end else if (rd_cap_lo) begin
            temp_hi <= capture_value_reg[15:8];
        end else if (rd_cnt_lo) begin
            temp_hi <= counter_value[15:8];
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= '0;
            irq_mask <= '0;
        end else begin
            if (wr_ctrl_a) begin
                ctrl.mode[1:0] <=
                    wr_byte[timer16_cc_pkg::CTRLA_MODE_LSB +: 2];
            end
            if (wr_ctrl_b) begin
                ctrl.mode[3:2] <=
                    wr_byte[timer16_cc_pkg::CTRLB_MODE_LSB +: 2];
                ctrl.edge_rise <= wr_byte[timer16_cc_pkg::CTRLB_EDGE_BIT];
                ctrl.filt_en <= wr_byte[timer16_cc_pkg::CTRLB_FILT_BIT];
            end
            if (wr_acmp) begin
                ctrl.cap_sel <= wr_byte[timer16_cc_pkg::ACMP_SEL_BIT];
            end
            if (wr_mask) begin
                irq_mask.cap <= wr_byte[timer16_cc_pkg::IRQ_CAP_BIT];
                irq_mask.cmp_a <= wr_byte[timer16_cc_pkg::IRQ_CMPA_BIT];
                irq_mask.cmp_b <= wr_byte[timer16_cc_pkg::IRQ_CMPB_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Trigger path: synchroniser, source select, filter, edge
    // ------------------------------------------------------------
    // pin_meta feeds only pin_sync2; bit 0 pin, bit 1 comparator.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta <= 2'b00;
            pin_sync2 <= 2'b00;
        end else begin
            pin_meta <= {comparator_output, capture_input_pin};
            pin_sync2 <= pin_meta;
        end
    end

    wire trig_raw = ctrl.cap_sel ? pin_sync2[1] : pin_sync2[0];
    wire filt_agree_hi = &filt_pipe;
    wire filt_agree_lo = ~|filt_pipe;
    wire filt_level = filt_agree_hi || (filt_out && !filt_agree_lo);

    // Filter runs every system clock regardless of the timer tick.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filt_pipe <= '0;
            filt_out <= 1'b0;
        end else begin
            filt_pipe <= {filt_pipe[FILT_DEPTH-2:0], trig_raw};
            filt_out <= filt_level;
        end
    end

    wire edge_in = ctrl.filt_en ? filt_level : trig_raw;
    wire edge_hit = ctrl.edge_rise ? (edge_in && !edge_prev) :
                                     (!edge_in && edge_prev);
    wire capture_go = edge_hit && !mode_cap_top;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            edge_prev <= 1'b0;
        end else begin
            edge_prev <= edge_in;
        end
    end

    // ------------------------------------------------------------
    // Capture value register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capture_value_reg <= timer16_cc_pkg::COUNT_RESET;
        end else if (capture_go) begin
            capture_value_reg <= counter_value;
        end else if (wr_cap_lo && mode_cap_top) begin
            capture_value_reg <= wr_word;
        end
    end

    // ------------------------------------------------------------
    // Counter and compare-match blocking
    // ------------------------------------------------------------
    // Wraps at top, or at TOP_MAX when above top; counts up in every mode, no mode counts down.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter_value <= timer16_cc_pkg::COUNT_RESET;
        end else if (wr_cnt_lo) begin
            counter_value <= wr_word;
        end else if (reload) begin
            counter_value <= timer16_cc_pkg::COUNT_RESET;
        end else if (timer_tick) begin
            counter_value <= counter_value + timer16_cc_pkg::COUNT_STEP;
        end
    end

    // Blocking stays armed while stopped until one tick consumes it.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            block_match <= 1'b0;
        end else if (wr_cnt_lo) begin
            block_match <= 1'b1;
        end else if (timer_tick) begin
            block_match <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Compare registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_a_active <= timer16_cc_pkg::COUNT_RESET;
            cmp_b_active <= timer16_cc_pkg::COUNT_RESET;
            cmp_a_buf <= timer16_cc_pkg::COUNT_RESET;
            cmp_b_buf <= timer16_cc_pkg::COUNT_RESET;
        end else begin
            if (wr_a_lo && mode_pwm) begin
                cmp_a_buf <= wr_word;
            end
            if (wr_b_lo && mode_pwm) begin
                cmp_b_buf <= wr_word;
            end
            if (wr_a_lo && !mode_pwm) begin
                cmp_a_active <= wr_word;
            end else if (mode_pwm && reload) begin
                cmp_a_active <= cmp_a_buf;
            end
            if (wr_b_lo && !mode_pwm) begin
                cmp_b_active <= wr_word;
            end else if (mode_pwm && reload) begin
                cmp_b_active <= cmp_b_buf;
            end
        end
    end

    assign compare_a_match = (counter_value == cmp_a_active);
    assign compare_b_match = (counter_value == cmp_b_active);
    wire set_a = timer_tick && compare_a_match && !block_match;
    wire set_b = timer_tick && compare_b_match && !block_match;

    // ------------------------------------------------------------
    // Flags: hardware set wins over every clear
    // ------------------------------------------------------------
    wire clr_cap = capture_irq_ack ||
        (wr_flag && wr_byte[timer16_cc_pkg::IRQ_CAP_BIT]);
    wire clr_a = compare_a_irq_ack ||
        (wr_flag && wr_byte[timer16_cc_pkg::IRQ_CMPA_BIT]);
    wire clr_b = compare_b_irq_ack ||
        (wr_flag && wr_byte[timer16_cc_pkg::IRQ_CMPB_BIT]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags <= '0;
        end else begin
            flags.cap <= capture_go || (flags.cap && !clr_cap);
            flags.cmp_a <= set_a || (flags.cmp_a && !clr_a);
            flags.cmp_b <= set_b || (flags.cmp_b && !clr_b);
        end
    end

    assign capture_irq = flags.cap && irq_mask.cap;
    assign compare_a_irq = flags.cmp_a && irq_mask.cmp_a;
    assign compare_b_irq = flags.cmp_b && irq_mask.cmp_b;

endmodule

`default_nettype wire

// ---- rtl/timer16_cc_pkg.sv ----
package timer16_cc_pkg;

    // ------------------------------------------------------------
    // Register byte addresses (one byte register per 32-bit word)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_COUNT_LO = 8'h00;
    localparam logic [7:0] OFF_COUNT_HI = 8'h04;
    localparam logic [7:0] OFF_CAP_LO = 8'h08;
    localparam logic [7:0] OFF_CAP_HI = 8'h0C;
    localparam logic [7:0] OFF_CMPA_LO = 8'h10;
    localparam logic [7:0] OFF_CMPA_HI = 8'h14;
    localparam logic [7:0] OFF_CMPB_LO = 8'h18;
    localparam logic [7:0] OFF_CMPB_HI = 8'h1C;
    localparam logic [7:0] OFF_CTRL_A = 8'h20;
    localparam logic [7:0] OFF_CTRL_B = 8'h24;
    localparam logic [7:0] OFF_ACMP_CTRL = 8'h28;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h2C;
    localparam logic [7:0] OFF_IRQ_FLAG = 8'h30;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRLA_MODE_LSB = 0;
    localparam int CTRLB_MODE_LSB = 3;
    localparam int CTRLB_EDGE_BIT = 6;
    localparam int CTRLB_FILT_BIT = 7;
    localparam int ACMP_SEL_BIT = 2;
    localparam int IRQ_CAP_BIT = 0;
    localparam int IRQ_CMPA_BIT = 1;
    localparam int IRQ_CMPB_BIT = 2;

    // ------------------------------------------------------------
    // Waveform modes and fixed top values
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_CTC_A = 4'h4;
    localparam logic [3:0] MODE_CTC_CAP = 4'hC;
    localparam logic [3:0] MODE_RSVD = 4'hD;
    localparam logic [15:0] TOP_MAX = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_STEP = 16'h0001;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [3:0] mode;
        logic filt_en;
        logic edge_rise;
        logic cap_sel;
    } ctrl_t;

    typedef struct packed {
        logic cap;
        logic cmp_a;
        logic cmp_b;
    } irq_t;

endpackage

// ---- verification/timer16_cc_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module timer16_cc_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus handshakes
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timer side
    input wire logic timer_tick,
    input wire logic capture_irq,
    input wire logic compare_a_irq,
    input wire logic [15:0] counter_value,
    input wire logic compare_a_match
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp lost");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata lost");
    a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while busy");
    a_aw_busy: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("write overlap");
    a_rd_lat: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    a_cnt_cause: assert property ($changed(counter_value)
        |-> $past(timer_tick) || $rose(s_axi_bvalid))
        else $error("counter moved without cause");
    a_match_cause: assert property ($changed(compare_a_match)
        |-> $changed(counter_value) || $rose(s_axi_bvalid) || $past(timer_tick))
        else $error("match moved without cause");
    a_cmp_irq_src: assert property ($rose(compare_a_irq)
        |-> $past(timer_tick) || $rose(s_axi_bvalid))
        else $error("compare request without cause");
    c_cap: cover property ($rose(capture_irq));
    c_cmp: cover property ($rose(compare_a_irq));
    c_load: cover property ($changed(counter_value) && !$past(timer_tick));
endmodule
bind timer16_capture_compare timer16_cc_checker chk_u (.aclk, .aresetn,
    .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .timer_tick, .capture_irq,
    .compare_a_irq, .counter_value, .compare_a_match);
`default_nettype wire

// ---- verification/timer16_event_src.sv ----
`timescale 1ns/1ps
`default_nettype none
module timer16_event_src (
    // Clock and requests
    input wire logic aclk,
    input wire logic go_pin,
    input wire logic go_cmp,
    // Event lines
    output logic capture_input_pin,
    output logic comparator_output
);
    initial {capture_input_pin, comparator_output} = 2'h0;
    // Skewed off the edge: both lines are asynchronous to the block
    always @(posedge aclk) begin
        capture_input_pin <= #7 go_pin;
        comparator_output <= #7 go_cmp;
    end
endmodule
`default_nettype wire

// ---- verification/tb_timer16_capture_compare.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_timer16_capture_compare;
    logic aclk, aresetn, timer_tick, capture_irq_ack, go_pin, go_cmp;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, capture_irq, compare_a_irq;
    logic capture_input_pin, comparator_output, compare_a_match, compare_b_irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [15:0] counter_value, v, d;
    int error_cnt = 0, compares = 0, cyc = 0, n0, n1;
    timer16_capture_compare dut_u (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .timer_tick, .capture_input_pin, .comparator_output, .capture_irq,
        .compare_a_irq, .compare_b_irq, .capture_irq_ack,
        .compare_a_irq_ack(1'b0), .compare_b_irq_ack(1'b0), .counter_value,
        .compare_a_match, .compare_b_match());
    timer16_event_src src_u (.aclk, .go_pin, .go_cmp, .capture_input_pin,
        .comparator_output);
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    task automatic wrap_up();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, x};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] x);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        x = s_axi_rdata[15:0];
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // High byte goes first so the low write completes the value
    task automatic w16(input logic [7:0] hi, input logic [15:0] x);
        wr(hi, x[15:8]);
        wr(hi - 8'h04, x[7:0]);
    endtask
    task automatic r16(input logic [7:0] hi, output logic [15:0] x);
        logic [15:0] lo;
        rd(hi - 8'h04, lo);
        rd(hi, x);
        x = {x[7:0], lo[7:0]};
    endtask
    task automatic ev(input logic c, output int n);
        n = 0;
        @(posedge aclk);
        if (c) go_cmp <= 1'b1;
        else go_pin <= 1'b1;
        while (capture_irq !== 1'b1 && n < 40) begin
            @(posedge aclk);
            n++;
        end
        {go_pin, go_cmp} <= 2'h0;
        repeat (12) @(posedge aclk);
    endtask
    task automatic tk();
        @(posedge aclk);
        timer_tick <= 1'b1;
        @(posedge aclk);
        timer_tick <= 1'b0;
    endtask
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, timer_tick, capture_irq_ack, go_pin, go_cmp} = '0;
        {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        v = 16'($urandom(32'h5078));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        w16(timer16_cc_pkg::OFF_COUNT_HI, v);
        wr(timer16_cc_pkg::OFF_CTRL_B, 8'h40);
        wr(timer16_cc_pkg::OFF_IRQ_MASK, 8'h07);
        ev(1'b0, n0);
        r16(timer16_cc_pkg::OFF_CAP_HI, d);
        chk(d, v);
        chk({15'h0000, capture_irq}, 16'h0001);
        rd(timer16_cc_pkg::OFF_IRQ_FLAG, d);
        chk(d, 16'h0001);
        wr(timer16_cc_pkg::OFF_IRQ_FLAG, 8'h00);
        rd(timer16_cc_pkg::OFF_IRQ_FLAG, d);
        chk(d, 16'h0001);
        wr(timer16_cc_pkg::OFF_IRQ_FLAG, 8'h01);
        rd(timer16_cc_pkg::OFF_IRQ_FLAG, d);
        chk(d, 16'h0000);
        ev(1'b0, n1);
        wr(timer16_cc_pkg::OFF_IRQ_FLAG, 8'h01);
        v = 16'($urandom);
        w16(timer16_cc_pkg::OFF_COUNT_HI, v);
        ev(1'b0, n1);
        r16(timer16_cc_pkg::OFF_CAP_HI, d);
        chk(d, v);
        @(posedge aclk) capture_irq_ack <= 1'b1;
        @(posedge aclk) capture_irq_ack <= 1'b0;
        @(posedge aclk);
        chk({15'h0000, capture_irq}, 16'h0000);
        wr(timer16_cc_pkg::OFF_CTRL_B, 8'hC0);
        ev(1'b0, n1);
        chk(16'(n1 - n0), 16'h0004);
        wr(timer16_cc_pkg::OFF_CTRL_B, 8'h40);
        wr(timer16_cc_pkg::OFF_ACMP_CTRL, 8'h04);
        wr(timer16_cc_pkg::OFF_IRQ_FLAG, 8'h01);
        ev(1'b1, n1);
        chk(16'(n1), 16'(n0));
        wr(timer16_cc_pkg::OFF_IRQ_FLAG, 8'h01);
        ev(1'b0, n1);
        chk(16'(n1), 16'h0028);
        wr(timer16_cc_pkg::OFF_ACMP_CTRL, 8'h00);
        wr(timer16_cc_pkg::OFF_CTRL_B, 8'h58);
        w16(timer16_cc_pkg::OFF_CAP_HI, v + 16'h1234);
        r16(timer16_cc_pkg::OFF_CAP_HI, d);
        chk(d, v + 16'h1234);
        ev(1'b0, n1);
        chk(16'(n1), 16'h0028);
        wr(timer16_cc_pkg::OFF_CTRL_B, 8'h40);
        w16(timer16_cc_pkg::OFF_CAP_HI, v);
        r16(timer16_cc_pkg::OFF_CAP_HI, d);
        chk(d, v + 16'h1234);
        w16(timer16_cc_pkg::OFF_CMPA_HI, v + 16'h0001);
        w16(timer16_cc_pkg::OFF_COUNT_HI, v);
        tk();
        tk();
        rd(timer16_cc_pkg::OFF_IRQ_FLAG, d);
        chk(d, 16'h0002);
        chk({15'h0000, compare_a_irq}, 16'h0001);
        wr(timer16_cc_pkg::OFF_IRQ_FLAG, 8'h02);
        chk({15'h0000, compare_a_irq}, 16'h0000);
        w16(timer16_cc_pkg::OFF_CMPB_HI, v + 16'h0005);
        w16(timer16_cc_pkg::OFF_COUNT_HI, v + 16'h0005);
        tk();
        rd(timer16_cc_pkg::OFF_IRQ_FLAG, d);
        chk(d, 16'h0000);
        chk({15'h0000, compare_b_irq}, 16'h0000);
        rd(8'h34, d);
        chk(16'(r), 16'(timer16_cc_pkg::RESP_SLVERR));
        wrap_up();
    end
endmodule
`default_nettype wire
